/* File: rtl/io_port_pkg.sv */
/*
 * Constants for the interpreter's variable space and I/O port: the sizes,
 * the byte, word and bit address maps, the access-size codes and the
 * reset values.
 * Assumes it is compiled before every module that refers to it.
 */
package io_port_pkg;

  localparam int VAR_BYTES       = 16;
  localparam int DATA_BYTES      = 14;
  localparam int DATA_WORDS      = 7;
  localparam int PORT_BITS       = 8;
  localparam int VAR_ADDR_W      = 5;
  localparam int DATA_WORD_AW    = 3;
  localparam int PROG_ADDR_W     = 8;

  // byte map
  localparam logic [4:0] BYTE_PIN_VALUE     = 5'h00;
  localparam logic [4:0] BYTE_PIN_DIRECTION = 5'h01;
  localparam logic [4:0] BYTE_DATA_FIRST    = 5'h02;
  localparam logic [4:0] BYTE_DATA_LAST     = 5'h0F;
  // word map
  localparam logic [4:0] WORD_PORT          = 5'h00;
  localparam logic [4:0] WORD_DATA_FIRST    = 5'h01;
  localparam logic [4:0] WORD_DATA_LAST     = 5'h07;
  // bit map
  localparam logic [4:0] BIT_PIN_VALUE_LO   = 5'h00;
  localparam logic [4:0] BIT_PIN_DIR_LO     = 5'h08;
  localparam logic [4:0] BIT_FLAG_LO        = 5'h10;

  // access size codes
  localparam logic [1:0] ACC_BYTE = 2'h0;
  localparam logic [1:0] ACC_WORD = 2'h1;
  localparam logic [1:0] ACC_BIT  = 2'h2;

  // reset values
  localparam logic [7:0]  PIN_VALUE_RST = 8'h00;
  localparam logic [7:0]  PIN_DIR_RST   = 8'h00;
  localparam logic [15:0] DATA_RST      = 16'h0000;
  localparam logic [7:0]  PROG_ADDR_RST = 8'h00;

endpackage : io_port_pkg

/* File: rtl/var_data_ram.sv */
/*
 * Seven 16-bit data words with a per-bit write mask and a registered
 * read port.
 * Assumes one clock, an active-low asynchronous reset, and that read and
 * write are never requested in the same cycle.
 */
`timescale 1ns/1ps
module var_data_ram #(
  parameter int WORDS = io_port_pkg::DATA_WORDS,
  parameter int AW    = io_port_pkg::DATA_WORD_AW
) (
  input  wire logic          clk_i,
  input  wire logic          arst_n_i,
  input  wire logic          clear_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [15:0]   wdata_i,
  input  wire logic [15:0]   wmask_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] raddr_i,
  input  wire logic          re_i,
  output logic      [15:0]   rdata_o
);

  logic [15:0] mem_r [WORDS];

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      for (int i = 0; i < WORDS; i++)
        mem_r[i] <= io_port_pkg::DATA_RST;
    end
    else if (clear_i)
    begin
      for (int i = 0; i < WORDS; i++)
        mem_r[i] <= io_port_pkg::DATA_RST;
    end
    else if (we_i && (int'(waddr_i) < WORDS))
    begin
      mem_r[waddr_i] <= (mem_r[waddr_i] & ~wmask_i) | (wdata_i & wmask_i);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rdata_o <= io_port_pkg::DATA_RST;
    else if (re_i)
      rdata_o <= (int'(raddr_i) < WORDS) ? mem_r[raddr_i] : 16'h0000;
  end

endmodule : var_data_ram

/* File: rtl/io_port_variable_map.sv */
/*
 * Variable space and eight-bit I/O port of a small interpreter controller:
 * pin-value and direction bytes, fourteen data bytes with a word view and
 * a bit view of the first data word, transfer of both port bytes to the
 * pins at each instruction start, the open-drain reset line and the
 * eight-bit program address.
 * Assumes all inputs except ARST_N_I are synchronous to CORE_CLK_I and that the
 * interpreter pulses INSN_START_I once before each instruction.
 */
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
module io_port_variable_map #(
  parameter int PINS = io_port_pkg::PORT_BITS
) (
  input  wire logic                        CORE_CLK_I,
  input  wire logic                        ARST_N_I,
  // variable access port
  input  wire logic [io_port_pkg::VAR_ADDR_W-1:0] VAR_ADDR_I,
  input  wire logic [1:0]                  VAR_SIZE_I,
  input  wire logic [15:0]                 VAR_WDATA_I,
  input  wire logic                        VAR_WR_I,
  input  wire logic                        VAR_RD_I,
  output logic      [15:0]                 VAR_RDATA_O,
  // instruction sequencing
  input  wire logic                        INSN_START_I,
  input  wire logic                        PROG_LOAD_I,
  input  wire logic [io_port_pkg::PROG_ADDR_W-1:0] PROG_LOAD_ADDR_I,
  input  wire logic                        PROG_STEP_I,
  output logic      [io_port_pkg::PROG_ADDR_W-1:0] PROG_ADDR_O,
  // general I/O pins
  input  wire logic [PINS-1:0]             GENERAL_IO_PINS_I,
  output logic      [PINS-1:0]             GENERAL_IO_PINS_O,
  output logic      [PINS-1:0]             GENERAL_IO_PINS_OE_O,
  // open-drain reset line
  input  wire logic                        LOW_SUPPLY_I,
  input  wire logic                        RESET_LINE_I,
  output logic                             RESET_LINE_O,
  output logic                             RESET_LINE_OE_O
);

  typedef enum {SEL_PORT_BYTE, SEL_PORT_WORD, SEL_PORT_BIT,
                SEL_DATA_BYTE, SEL_DATA_WORD, SEL_DATA_BIT,
                SEL_NONE} rd_sel_e;

  logic [PINS-1:0] pin_value_byte_r;
  logic [PINS-1:0] pin_direction_byte_r;
  logic [PINS-1:0] pin_drive_r;
  logic [PINS-1:0] pin_dir_hw_r;
  logic [PINS-1:0] pin_live_r;
  rd_sel_e         rd_sel_r;
  logic [4:0]      rd_addr_r;
  rd_sel_e         rd_sel_nxt;
  logic [PINS-1:0] rd_dir_r;
  logic            line_reset;

  logic [2:0]      ram_waddr;
  logic [15:0]     ram_wdata;
  logic [15:0]     ram_wmask;
  logic            ram_we;
  logic [2:0]      ram_raddr;
  logic            ram_re;
  logic [15:0]     ram_rdata;
  logic [4:0]      data_byte;
  logic [4:0]      data_bit;
  logic [4:0]      port_bit;
  logic [PINS-1:0] pv_nxt;
  logic [PINS-1:0] pd_nxt;
  logic [7:0]      rd_byte;
  logic [7:0]      ram_byte;
  logic            rd_bit;

  // external pull-down on the reset line resets the variable space
  assign line_reset = !RESET_LINE_I;

  // device only ever pulls the line low; released otherwise
  assign RESET_LINE_O    = 1'b0;
  assign RESET_LINE_OE_O = LOW_SUPPLY_I;

  assign data_byte = VAR_ADDR_I - io_port_pkg::BYTE_DATA_FIRST;
  assign data_bit  = VAR_ADDR_I - io_port_pkg::BIT_FLAG_LO;
  assign port_bit  = VAR_ADDR_I - io_port_pkg::BIT_PIN_DIR_LO;

  // write decode for the fourteen data bytes and flags
  always_comb
  begin
    ram_waddr = 3'h0;
    ram_wdata = 16'h0000;
    ram_wmask = 16'h0000;
    ram_we    = 1'b0;
    case (VAR_SIZE_I)
      io_port_pkg::ACC_BYTE:
      begin
        if ((VAR_ADDR_I >= io_port_pkg::BYTE_DATA_FIRST) &&
            (VAR_ADDR_I <= io_port_pkg::BYTE_DATA_LAST))
        begin
          ram_waddr = data_byte[3:1];
          ram_wdata = {VAR_WDATA_I[7:0], VAR_WDATA_I[7:0]};
          ram_wmask = data_byte[0] ? 16'hFF00 : 16'h00FF;
          ram_we    = VAR_WR_I;
        end
      end
      io_port_pkg::ACC_WORD:
      begin
        if ((VAR_ADDR_I >= io_port_pkg::WORD_DATA_FIRST) &&
            (VAR_ADDR_I <= io_port_pkg::WORD_DATA_LAST))
        begin
          ram_waddr = 3'(VAR_ADDR_I - io_port_pkg::WORD_DATA_FIRST);
          ram_wdata = VAR_WDATA_I;
          ram_wmask = 16'hFFFF;
          ram_we    = VAR_WR_I;
        end
      end
      io_port_pkg::ACC_BIT:
      begin
        if (VAR_ADDR_I >= io_port_pkg::BIT_FLAG_LO)
        begin
          ram_waddr = 3'h0;
          ram_wdata = {16{VAR_WDATA_I[0]}};
          ram_wmask = 16'h0001 << data_bit[3:0];
          ram_we    = VAR_WR_I;
        end
      end
      default:
      begin
        ram_we = 1'b0;
      end
    endcase
  end

  // read address for the data memory
  always_comb
  begin
    ram_raddr = 3'h0;
    ram_re    = VAR_RD_I;
    case (VAR_SIZE_I)
      io_port_pkg::ACC_BYTE: ram_raddr = data_byte[3:1];
      io_port_pkg::ACC_WORD: ram_raddr = 3'(VAR_ADDR_I - 5'h01);
      io_port_pkg::ACC_BIT:  ram_raddr = 3'h0;
      default:               ram_re    = 1'b0;
    endcase
  end

  var_data_ram #(
    .WORDS (io_port_pkg::DATA_WORDS),
    .AW    (io_port_pkg::DATA_WORD_AW)
  ) u_data (
    .clk_i    (CORE_CLK_I),
    .arst_n_i (ARST_N_I),
    .clear_i  (line_reset),
    .waddr_i  (ram_waddr),
    .wdata_i  (ram_wdata),
    .wmask_i  (ram_wmask),
    .we_i     (ram_we),
    .raddr_i  (ram_raddr),
    .re_i     (ram_re),
    .rdata_o  (ram_rdata)
  );

  // next values of the two port bytes for byte, word and bit writes
  always_comb
  begin
    pv_nxt = pin_value_byte_r;
    pd_nxt = pin_direction_byte_r;
    if (VAR_WR_I)
    begin
      case (VAR_SIZE_I)
        io_port_pkg::ACC_BYTE:
        begin
          if (VAR_ADDR_I == io_port_pkg::BYTE_PIN_VALUE)
            pv_nxt = VAR_WDATA_I[7:0];
          if (VAR_ADDR_I == io_port_pkg::BYTE_PIN_DIRECTION)
            pd_nxt = VAR_WDATA_I[7:0];
        end
        io_port_pkg::ACC_WORD:
        begin
          if (VAR_ADDR_I == io_port_pkg::WORD_PORT)
          begin
            pv_nxt = VAR_WDATA_I[7:0];
            pd_nxt = VAR_WDATA_I[15:8];
          end
        end
        io_port_pkg::ACC_BIT:
        begin
          if (VAR_ADDR_I < io_port_pkg::BIT_PIN_DIR_LO)
            pv_nxt[VAR_ADDR_I[2:0]] = VAR_WDATA_I[0];
          else if (VAR_ADDR_I < io_port_pkg::BIT_FLAG_LO)
            pd_nxt[port_bit[2:0]] = VAR_WDATA_I[0];
        end
        default:
        begin
          pv_nxt = pin_value_byte_r;
        end
      endcase
    end
  end

  // ram copies of the port bytes; direction clears to all inputs
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      pin_value_byte_r     <= io_port_pkg::PIN_VALUE_RST;
      pin_direction_byte_r <= io_port_pkg::PIN_DIR_RST;
    end
    else if (line_reset)
    begin
      pin_value_byte_r     <= io_port_pkg::PIN_VALUE_RST;
      pin_direction_byte_r <= io_port_pkg::PIN_DIR_RST;
    end
    else
    begin
      pin_value_byte_r     <= pv_nxt;
      pin_direction_byte_r <= pd_nxt;
    end
  end

  // port hardware loads only at instruction start
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      pin_drive_r  <= io_port_pkg::PIN_VALUE_RST;
      pin_dir_hw_r <= io_port_pkg::PIN_DIR_RST;
    end
    else if (line_reset)
    begin
      pin_drive_r  <= io_port_pkg::PIN_VALUE_RST;
      pin_dir_hw_r <= io_port_pkg::PIN_DIR_RST;
    end
    else if (INSN_START_I)
    begin
      pin_drive_r  <= pin_value_byte_r;
      pin_dir_hw_r <= pin_direction_byte_r;
    end
  end

  // a 1 drives the pin, a 0 leaves it as input
  assign GENERAL_IO_PINS_O    = pin_drive_r;
  assign GENERAL_IO_PINS_OE_O = pin_dir_hw_r;

  // which view a read strobe selects; unmapped reads give zero
  always_comb
  begin
    rd_sel_nxt = SEL_NONE;
    case (VAR_SIZE_I)
      io_port_pkg::ACC_BYTE:
      begin
        if (VAR_ADDR_I < io_port_pkg::BYTE_DATA_FIRST)
          rd_sel_nxt = SEL_PORT_BYTE;
        else if (VAR_ADDR_I <= io_port_pkg::BYTE_DATA_LAST)
          rd_sel_nxt = SEL_DATA_BYTE;
      end
      io_port_pkg::ACC_WORD:
      begin
        if (VAR_ADDR_I == io_port_pkg::WORD_PORT)
          rd_sel_nxt = SEL_PORT_WORD;
        else if (VAR_ADDR_I <= io_port_pkg::WORD_DATA_LAST)
          rd_sel_nxt = SEL_DATA_WORD;
      end
      io_port_pkg::ACC_BIT:
      begin
        if (VAR_ADDR_I < io_port_pkg::BIT_FLAG_LO)
          rd_sel_nxt = SEL_PORT_BIT;
        else
          rd_sel_nxt = SEL_DATA_BIT;
      end
      default:
      begin
        rd_sel_nxt = SEL_NONE;
      end
    endcase
  end

  // selection stays until the next read so the answer stands
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      rd_sel_r <= SEL_NONE;
    else if (VAR_RD_I)
      rd_sel_r <= rd_sel_nxt;
  end

  // read capture: pins sampled live at the strobe, direction held with
  // them so a later write cannot change an answer already given
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      rd_addr_r  <= 5'h00;
      pin_live_r <= '0;
      rd_dir_r   <= '0;
    end
    else if (VAR_RD_I)
    begin
      rd_addr_r  <= VAR_ADDR_I;
      pin_live_r <= GENERAL_IO_PINS_I;
      rd_dir_r   <= pin_direction_byte_r;
    end
  end

  // read data, one cycle after the strobe
  always_comb
  begin
    rd_byte = rd_addr_r[0] ? rd_dir_r : pin_live_r;
    rd_bit  = rd_addr_r[3] ? rd_dir_r[rd_addr_r[2:0]]
                           : pin_live_r[rd_addr_r[2:0]];
    if (rd_addr_r[0])
      ram_byte = ram_rdata[15:8];
    else
      ram_byte = ram_rdata[7:0];
    case (rd_sel_r)
      SEL_PORT_BYTE: VAR_RDATA_O = {8'h00, rd_byte};
      SEL_PORT_WORD: VAR_RDATA_O = {rd_dir_r, pin_live_r};
      SEL_PORT_BIT:  VAR_RDATA_O = {15'h0000, rd_bit};
      SEL_DATA_BYTE: VAR_RDATA_O = {8'h00, ram_byte};
      SEL_DATA_WORD: VAR_RDATA_O = ram_rdata;
      SEL_DATA_BIT:  VAR_RDATA_O = {15'h0000, ram_rdata[rd_addr_r[3:0]]};
      default:       VAR_RDATA_O = 16'h0000;
    endcase
  end

  // eight-bit program counter wraps within 256 bytes
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      PROG_ADDR_O <= io_port_pkg::PROG_ADDR_RST;
    else if (line_reset)
      PROG_ADDR_O <= io_port_pkg::PROG_ADDR_RST;
    else if (PROG_LOAD_I)
      PROG_ADDR_O <= PROG_LOAD_ADDR_I;
    else if (PROG_STEP_I)
      PROG_ADDR_O <= PROG_ADDR_O + 8'h01;
  end

endmodule : io_port_variable_map

/* File: tb/io_port_checker_assertions.sv */
/*
 * Port-level checker for the variable map and I/O port.
 * Assumes one clock, the one-cycle read latency and that a low reset
 * line acts as a synchronous clear of the block.
 */
`timescale 1ns/1ps
module io_port_checker #(
  parameter int PINS = 8
) (
  input wire logic            CORE_CLK_I,
  input wire logic            ARST_N_I,
  input wire logic [4:0]      VAR_ADDR_I,
  input wire logic [1:0]      VAR_SIZE_I,
  input wire logic            VAR_RD_I,
  input wire logic [15:0]     VAR_RDATA_O,
  input wire logic            INSN_START_I,
  input wire logic            PROG_LOAD_I,
  input wire logic [7:0]      PROG_LOAD_ADDR_I,
  input wire logic            PROG_STEP_I,
  input wire logic [7:0]      PROG_ADDR_O,
  input wire logic [PINS-1:0] GENERAL_IO_PINS_I,
  input wire logic [PINS-1:0] GENERAL_IO_PINS_O,
  input wire logic [PINS-1:0] GENERAL_IO_PINS_OE_O,
  input wire logic            LOW_SUPPLY_I,
  input wire logic            RESET_LINE_I,
  input wire logic            RESET_LINE_O,
  input wire logic            RESET_LINE_OE_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  sequence s_rd_pins;
    VAR_RD_I && VAR_SIZE_I == io_port_pkg::ACC_BYTE
      && VAR_ADDR_I == io_port_pkg::BYTE_PIN_VALUE;
  endsequence
  sequence s_rd_port;
    VAR_RD_I && VAR_SIZE_I == io_port_pkg::ACC_WORD
      && VAR_ADDR_I == io_port_pkg::WORD_PORT;
  endsequence
  a_pins_live: assert property (
    s_rd_pins |=> VAR_RDATA_O == {8'h00, $past(GENERAL_IO_PINS_I)})
    else $error("pin byte read does not show live pins");
  a_port_word_low: assert property (
    s_rd_port |=> VAR_RDATA_O[7:0] == $past(GENERAL_IO_PINS_I))
    else $error("port word low byte does not show live pins");
  a_out_hold: assert property (
    !INSN_START_I && RESET_LINE_I |=> $stable(GENERAL_IO_PINS_O))
    else $error("pin drive changed without instruction start");
  a_dir_hold: assert property (
    !INSN_START_I && RESET_LINE_I |=> $stable(GENERAL_IO_PINS_OE_O))
    else $error("direction changed without instruction start");
  a_dir_clear: assert property (
    !RESET_LINE_I |=> GENERAL_IO_PINS_OE_O == {PINS{1'b0}})
    else $error("direction not cleared by reset line");
  a_prog_step: assert property (
    PROG_STEP_I && !PROG_LOAD_I && RESET_LINE_I
      |=> PROG_ADDR_O == $past(PROG_ADDR_O) + 8'h01)
    else $error("program address step wrong");
  a_prog_load: assert property (
    PROG_LOAD_I && RESET_LINE_I |=> PROG_ADDR_O == $past(PROG_LOAD_ADDR_I))
    else $error("program address load wrong");
  a_reset_pull: assert property (
    RESET_LINE_OE_O == LOW_SUPPLY_I && !RESET_LINE_O)
    else $error("reset line drive wrong");
  a_size_none: assert property (
    VAR_RD_I && VAR_SIZE_I == 2'h3 |=> VAR_RDATA_O == 16'h0000)
    else $error("unmapped size read not zero");
endmodule : io_port_checker

bind io_port_variable_map io_port_checker #(.PINS(PINS)) chk_i (
  .CORE_CLK_I(CORE_CLK_I), .ARST_N_I(ARST_N_I), .VAR_ADDR_I(VAR_ADDR_I),
  .VAR_SIZE_I(VAR_SIZE_I), .VAR_RD_I(VAR_RD_I), .VAR_RDATA_O(VAR_RDATA_O),
  .INSN_START_I(INSN_START_I), .PROG_LOAD_I(PROG_LOAD_I),
  .PROG_LOAD_ADDR_I(PROG_LOAD_ADDR_I), .PROG_STEP_I(PROG_STEP_I),
  .PROG_ADDR_O(PROG_ADDR_O), .GENERAL_IO_PINS_I(GENERAL_IO_PINS_I),
  .GENERAL_IO_PINS_O(GENERAL_IO_PINS_O),
  .GENERAL_IO_PINS_OE_O(GENERAL_IO_PINS_OE_O), .LOW_SUPPLY_I(LOW_SUPPLY_I),
  .RESET_LINE_I(RESET_LINE_I), .RESET_LINE_O(RESET_LINE_O),
  .RESET_LINE_OE_O(RESET_LINE_OE_O));

/* File: tb/ext_pins.sv */
/*
 * External circuits on the port pins and the pulled-up reset line.
 * Assumes the bench chooses what the circuits drive on input pins.
 */
`timescale 1ns/1ps
module ext_pins (
  input  wire logic [7:0] pins_out_i,
  input  wire logic [7:0] pins_oe_i,
  input  wire logic [7:0] ext_drive_i,
  input  wire logic       rst_out_i,
  input  wire logic       rst_oe_i,
  input  wire logic       pull_low_i,
  output logic      [7:0] pins_in_o,
  output logic            rst_line_o
);
  // outputs win on their pins, the circuit drives the inputs
  assign pins_in_o = (pins_oe_i & pins_out_i)
                   | (~pins_oe_i & ext_drive_i);
  // pull-up; the outside only ever pulls low
  assign rst_line_o = (rst_oe_i ? rst_out_i : 1'b1) & !pull_low_i;
endmodule : ext_pins

/* File: tb/tb_top.sv */
/*
 * Self-checking bench for the variable map and I/O port.
 * Assumes the one-cycle read latency and pulse inputs of the design.
 */
`timescale 1ns/1ps
module tb_top;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [4:0]  var_addr = 5'h00;
  logic [1:0]  var_size = 2'h0;
  logic [15:0] var_wdata = 16'h0000;
  logic        var_wr = 1'b0, var_rd = 1'b0, insn = 1'b0;
  logic        p_load = 1'b0, p_step = 1'b0, low_sup = 1'b0, pull_low = 1'b0;
  logic [7:0]  p_addr = 8'h00, ext_drive = 8'h3C;
  wire logic [15:0] rdata;
  wire logic [7:0]  prog_addr, pins_in, pins_out, pins_oe;
  wire logic        rst_line, rst_o, rst_oe;
  int          errors = 0, cmp_count = 0;
  always #2.5 core_clk = ~core_clk;
  io_port_variable_map DUT (.CORE_CLK_I(core_clk), .ARST_N_I(arst_n),
    .VAR_ADDR_I(var_addr), .VAR_SIZE_I(var_size), .VAR_WDATA_I(var_wdata),
    .VAR_WR_I(var_wr), .VAR_RD_I(var_rd), .VAR_RDATA_O(rdata),
    .INSN_START_I(insn), .PROG_LOAD_I(p_load), .PROG_LOAD_ADDR_I(p_addr),
    .PROG_STEP_I(p_step), .PROG_ADDR_O(prog_addr),
    .GENERAL_IO_PINS_I(pins_in), .GENERAL_IO_PINS_O(pins_out),
    .GENERAL_IO_PINS_OE_O(pins_oe), .LOW_SUPPLY_I(low_sup),
    .RESET_LINE_I(rst_line), .RESET_LINE_O(rst_o), .RESET_LINE_OE_O(rst_oe));
  ext_pins ext (.pins_out_i(pins_out), .pins_oe_i(pins_oe),
    .ext_drive_i(ext_drive), .rst_out_i(rst_o), .rst_oe_i(rst_oe),
    .pull_low_i(pull_low), .pins_in_o(pins_in), .rst_line_o(rst_line));
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [1:0] sz,
                     input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    var_wr <= w;
    var_rd <= !w;
    var_size <= sz;
    var_addr <= a;
    var_wdata <= d;
    @(posedge core_clk);
    var_wr <= 1'b0;
    var_rd <= 1'b0;
    #1;
  endtask : acc
  task automatic rd(input logic [1:0] sz, input logic [4:0] a,
                    input logic [15:0] exp);
    acc(1'b0, sz, a, 16'h0000);
    chk(rdata, exp);
  endtask : rd
  task automatic ctl(input logic i, input logic l, input logic s,
                     input logic [7:0] la);
    @(posedge core_clk);
    insn <= i;
    p_load <= l;
    p_step <= s;
    p_addr <= la;
    @(posedge core_clk);
    insn <= 1'b0;
    p_load <= 1'b0;
    p_step <= 1'b0;
    #1;
  endtask : ctl
  initial
  begin
    repeat (5000) @(posedge core_clk);
    errors++;
    $display("unexpected at %0t: run did not end", $time);
    tally_and_finish();
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    #1;
    chk({8'h00, pins_oe}, 16'h0000);
    chk({8'h00, prog_addr}, 16'h0000);
    rd(io_port_pkg::ACC_BYTE, io_port_pkg::BYTE_PIN_DIRECTION,
       16'h0000);
    acc(1'b1, io_port_pkg::ACC_BYTE, io_port_pkg::BYTE_PIN_VALUE,
        16'h00A5);
    rd(io_port_pkg::ACC_BYTE, io_port_pkg::BYTE_PIN_VALUE, 16'h003C);
    acc(1'b1, io_port_pkg::ACC_BYTE, io_port_pkg::BYTE_PIN_DIRECTION,
        16'h000F);
    chk({pins_oe, pins_out}, 16'h0000);
    ctl(1'b1, 1'b0, 1'b0, 8'h00);
    chk({pins_oe, pins_out}, 16'h0FA5);
    rd(io_port_pkg::ACC_BYTE, io_port_pkg::BYTE_PIN_VALUE, 16'h0035);
    rd(io_port_pkg::ACC_WORD, io_port_pkg::WORD_PORT, 16'h0F35);
    acc(1'b1, io_port_pkg::ACC_WORD, io_port_pkg::WORD_PORT, 16'hF0C3);
    ctl(1'b1, 1'b0, 1'b0, 8'h00);
    chk({pins_oe, pins_out}, 16'hF0C3);
    // live pins are now 8'hCC
    for (int n = 0; n < 8; n++)
      rd(io_port_pkg::ACC_BIT, 5'(n), {15'h0000, n[1]});
    for (int k = 0; k < 7; k++)
      acc(1'b1, io_port_pkg::ACC_WORD, io_port_pkg::WORD_DATA_FIRST + 5'(k),
          {8'h41 + 8'(2 * k), 8'h40 + 8'(2 * k)});
    // a byte address past the data bytes must not alias into them
    acc(1'b1, io_port_pkg::ACC_BYTE, 5'h12, 16'h00FF);
    rd(io_port_pkg::ACC_BYTE, 5'h12, 16'h0000);
    for (int j = 0; j < 14; j++)
      rd(io_port_pkg::ACC_BYTE, io_port_pkg::BYTE_DATA_FIRST + 5'(j),
         16'h0040 + 16'(j));
    acc(1'b1, io_port_pkg::ACC_BYTE, io_port_pkg::BYTE_DATA_FIRST,
        16'h0000);
    acc(1'b1, io_port_pkg::ACC_BYTE, 5'h03, 16'h0000);
    for (int n = 0; n < 16; n += 3)
      acc(1'b1, io_port_pkg::ACC_BIT, io_port_pkg::BIT_FLAG_LO + 5'(n),
          16'h0001);
    rd(io_port_pkg::ACC_WORD, io_port_pkg::WORD_DATA_FIRST, 16'h9249);
    rd(io_port_pkg::ACC_BIT, io_port_pkg::BIT_FLAG_LO + 5'h04,
       16'h0000);
    acc(1'b1, io_port_pkg::ACC_BIT, io_port_pkg::BIT_PIN_DIR_LO + 5'h1,
        16'h0001);
    rd(io_port_pkg::ACC_BYTE, io_port_pkg::BYTE_PIN_DIRECTION,
       16'h00F2);
    acc(1'b1, io_port_pkg::ACC_WORD, 5'h08, 16'hFFFF);
    rd(io_port_pkg::ACC_WORD, 5'h08, 16'h0000);
    rd(io_port_pkg::ACC_WORD, io_port_pkg::WORD_DATA_LAST, 16'h4D4C);
    rd(2'h3, 5'h00, 16'h0000);
    ctl(1'b0, 1'b1, 1'b1, 8'hFE);
    chk({8'h00, prog_addr}, 16'h00FE);
    ctl(1'b0, 1'b0, 1'b1, 8'h00);
    ctl(1'b0, 1'b0, 1'b1, 8'h00);
    chk({8'h00, prog_addr}, 16'h0000);
    // non-zero address so the reset line clear below is visible
    ctl(1'b0, 1'b1, 1'b0, 8'h5A);
    @(posedge core_clk);
    pull_low <= 1'b1;
    @(posedge core_clk);
    pull_low <= 1'b0;
    #1;
    chk({pins_oe, prog_addr}, 16'h0000);
    rd(io_port_pkg::ACC_WORD, io_port_pkg::WORD_DATA_LAST, 16'h0000);
    @(posedge core_clk);
    low_sup <= 1'b1;
    #1;
    chk({14'h0000, rst_oe, rst_line}, 16'h0002);
    @(posedge core_clk);
    low_sup <= 1'b0;
    tally_and_finish();
  end
endmodule : tb_top
